// File: pkg/pdcf_pkg.sv
// constants and types for the pwm dead-time, carrier and fault output stage
`default_nettype none
package pdcf_pkg;
	// register word addresses on the plain port
	localparam int unsigned AW = 8;
	localparam logic [7:0] DT_CFG_ADDR = 8'h00;
	localparam logic [7:0] FALL_DLY_ADDR = 8'h04;
	localparam logic [7:0] RISE_DLY_ADDR = 8'h08;
	localparam logic [7:0] CHOP_CFG_ADDR = 8'h0c;
	localparam logic [7:0] FH_CFG_ADDR = 8'h10;
	localparam logic [7:0] FH_ACT_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;

	// dead-time switch positions inside dt_cfg
	localparam int unsigned SW_B_BYPASS = 0;
	localparam int unsigned SW_A_BYPASS = 1;
	localparam int unsigned SW_RISE_INV = 2;
	localparam int unsigned SW_FALL_INV = 3;
	localparam int unsigned SW_RISE_SEL = 4;
	localparam int unsigned SW_FALL_SEL = 5;
	localparam int unsigned SW_A_SWAP = 6;
	localparam int unsigned SW_B_SWAP = 7;
	localparam int unsigned SW_DUAL = 8;
	localparam int unsigned DELAY_CLOCK_SEL_BIT = 9;
	localparam int unsigned DT_CFG_W = 10;

	// chop_config fields
	localparam int unsigned CHOP_EN_BIT = 0;
	localparam int unsigned CHOP_PRE_LSB = 1;
	localparam int unsigned PRE_W = 4;
	localparam int unsigned CHOP_DUTY_LSB = 5;
	localparam int unsigned CHOP_OSW_LSB = 8;
	localparam int unsigned CHOP_CFG_W = 12;
	localparam int unsigned OS_SHIFT = 3;
	localparam int unsigned OS_W = 12;

	// fault handler configuration fields
	localparam int unsigned FH_EN_BIT = 0;
	localparam int unsigned FH_CBC_LSB = 1;
	localparam int unsigned FH_OST_LSB = 4;
	localparam int unsigned FH_REL_BIT = 7;
	localparam int unsigned FH_SWCBC_BIT = 8;
	localparam int unsigned FH_SWOST_BIT = 9;
	localparam int unsigned FH_CLR_BIT = 10;
	localparam int unsigned FH_CFG_W = 11;

	// values after reset
	localparam logic [9:0] DT_CFG_RST = 10'h003;
	localparam logic [15:0] DLY_RST = 16'h0000;
	localparam logic [11:0] CHOP_CFG_RST = 12'h000;
	localparam logic [10:0] FH_CFG_RST = 11'h000;
	localparam logic [15:0] FH_ACT_RST = 16'h0000;

	// forcing action per output and direction
	typedef enum logic [1:0] {
		PDCF_ACT_NONE = 2'b00,
		PDCF_ACT_LOW = 2'b01,
		PDCF_ACT_HIGH = 2'b10,
		PDCF_ACT_TOGGLE = 2'b11
	} pdcf_act_e;
endpackage
`default_nettype wire

// File: rtl/pdcf_top.sv
// dead-time generator, carrier chopper and fault handler of one pwm operator
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// one edge delay: holds the chosen edge back by value ticks, other edge passes
module pdcf_edge_delay #(
	parameter bit FALL = 1'b0,
	parameter int W = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// signal, tick and delay
	input wire logic x,
	input wire logic tick,
	input wire logic [W-1:0] value,
	output logic y
);
	logic s;
	logic done;
	logic [W-1:0] cnt;

	// work on the rising form of the signal; a fall delay inverts in and out
	assign s = x ^ FALL;
	assign done = cnt >= value;
	assign y = (s & done) ^ FALL;

	// tick count since the delayed edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
		end else if (!s) begin
			cnt <= '0;
		end else if (!done && tick) begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule

// Overview of operation
// - both bypass switches set pass both generator outputs unchanged.
// - no bypass, rise invert 0, fall invert 1 gives high complementary mode.
// - no bypass, rise invert 1, fall invert 0 gives low complementary mode.
// - no bypass, both inverts 0 is both-high, both 1 is both-low.
// - only A bypassed: A passes, B is A with falling delay.
// - only B bypassed: A is A with rising delay, B passes.
// - separate 16-bit rising and falling delay values, set independently.
// - delays count delay_clock periods, chosen from operator or timer clock.
// - carrier from prescaled operator clock; enable off passes signals unchopped.
// - first pulse lasts 8 x (prescale+1) x (width+1) operator clocks.
// - after the first pulse the high phase is chopped at carrier rate.
// - sustaining pulse duty is the three-bit duty field over 8.
// - each of three fault levels selects per-cycle, latched or no trip.
// - per-cycle trip forces each output high, low, toggle or none.
// - per-cycle forcing ends at the chosen zero or period point.
// - latched trip applies its per-output, per-direction action at once.
// - latched forcing persists until software toggles the clear control or disables fault handling.
// - status shows per-cycle and latched trip activity.
// - each fault raises its own per-cycle or latched event, only when selected for that trip.
// - software can force a trip; whole fault handling can be disabled.
// - nine switches steer the dead-time stage.
module pdcf_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// generator outputs and timer state
	input wire logic gen_a,
	input wire logic gen_b,
	input wire logic timer_up,
	input wire logic timer_at_zero,
	input wire logic timer_at_period,
	input wire logic timer_clock,
	// fault pins
	input wire logic fault_in_0,
	input wire logic fault_in_1,
	input wire logic fault_in_2,
	// driven outputs and events
	output logic operator_out_a,
	output logic operator_out_b,
	output logic per_cycle_trip_active,
	output logic latched_trip_active,
	output logic [2:0] per_cycle_event,
	output logic [2:0] latched_event
);
	logic [9:0] dt_cfg;
	logic [15:0] rise_delay_value;
	logic [15:0] fall_delay_value;
	logic [11:0] chop_config;
	logic [10:0] fh_cfg;
	logic [15:0] fh_act;
	logic sw_latched_pulse;
	logic clr_q;
	logic clr_tgl;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] lvl;
	logic tclk_q;
	logic dt_tick;
	logic [2:0] flt;
	logic [2:0] flt_q;
	logic [8:0] sw;
	logic red_in;
	logic fed_in;
	logic red_raw;
	logic fed_raw;
	logic a_dt;
	logic b_dt;
	logic [1:0] chop_in;
	logic [1:0] chop_out;
	logic [1:0] chop_q;
	logic chop_enable;
	logic [3:0] chop_prescale;
	logic [2:0] chop_duty;
	logic [3:0] first_pulse_width;
	logic [3:0] pre_cnt;
	logic [2:0] phase;
	logic chop_tick;
	logic carrier;
	logic [9:0] os_mult;
	logic [11:0] os_load;
	logic [11:0] os_left [2];
	logic fh_en;
	logic [2:0] per_cycle_src;
	logic [2:0] latched_src;
	logic per_cycle_hit;
	logic latched_hit;
	logic release_evt;
	logic per_cycle_on;
	logic latched_on;
	logic trip_now;
	logic [1:0] tog_lvl;
	logic [1:0] next_out;

	// register writes; the latched force bit acts only as a write pulse
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dt_cfg <= pdcf_pkg::DT_CFG_RST;
			fall_delay_value <= pdcf_pkg::DLY_RST;
			rise_delay_value <= pdcf_pkg::DLY_RST;
			chop_config <= pdcf_pkg::CHOP_CFG_RST;
			fh_cfg <= pdcf_pkg::FH_CFG_RST;
			fh_act <= pdcf_pkg::FH_ACT_RST;
		end else if (wr) begin
			case (addr)
				pdcf_pkg::DT_CFG_ADDR: dt_cfg <= wdata[9:0];
				pdcf_pkg::FALL_DLY_ADDR: fall_delay_value <= wdata[15:0];
				pdcf_pkg::RISE_DLY_ADDR: rise_delay_value <= wdata[15:0];
				pdcf_pkg::CHOP_CFG_ADDR: chop_config <= wdata[11:0];
				pdcf_pkg::FH_CFG_ADDR: fh_cfg <= wdata[10:0];
				pdcf_pkg::FH_ACT_ADDR: fh_act <= wdata[15:0];
				default: ;
			endcase
		end
	end
	assign sw_latched_pulse = wr && addr == pdcf_pkg::FH_CFG_ADDR
		&& wdata[pdcf_pkg::FH_SWOST_BIT];

	// read data one cycle after the strobe, zero for unmapped words
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= '0;
			if (rd) begin
				case (addr)
					pdcf_pkg::DT_CFG_ADDR: rdata <= {22'h0, dt_cfg};
					pdcf_pkg::FALL_DLY_ADDR: rdata <= {16'h0, fall_delay_value};
					pdcf_pkg::RISE_DLY_ADDR: rdata <= {16'h0, rise_delay_value};
					pdcf_pkg::CHOP_CFG_ADDR: rdata <= {20'h0, chop_config};
					pdcf_pkg::FH_CFG_ADDR: rdata <= {21'h0, fh_cfg};
					pdcf_pkg::FH_ACT_ADDR: rdata <= {16'h0, fh_act};
					pdcf_pkg::STATUS_ADDR: rdata <= {27'h0, flt, latched_on, per_cycle_on};
					default: rdata <= '0;
				endcase
			end
		end
	end

	// three-stage sync of timer clock and faults; a change counts once the
	// second and third stages agree, which filters one-cycle pad glitches
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			lvl <= '0;
			tclk_q <= 1'b0;
			flt_q <= '0;
		end else begin
			sync1 <= {fault_in_2, fault_in_1, fault_in_0, timer_clock};
			sync2 <= sync1;
			sync3 <= sync2;
			lvl <= (sync2 & sync3) | (lvl & (sync2 ^ sync3));
			tclk_q <= lvl[0];
			flt_q <= flt;
		end
	end
	assign flt = lvl[3:1];

	// delay clock: every operator clock, or each rising timer_clock edge
	assign dt_tick = dt_cfg[pdcf_pkg::DELAY_CLOCK_SEL_BIT] ? (lvl[0] & ~tclk_q) : 1'b1;

	// dead-time path; all nine switches steer the stage
	assign sw = dt_cfg[8:0];
	assign red_in = sw[pdcf_pkg::SW_RISE_SEL] ? gen_b : gen_a;
	assign fed_in = sw[pdcf_pkg::SW_DUAL] ? red_raw
		: (sw[pdcf_pkg::SW_FALL_SEL] ? gen_b : gen_a);

	pdcf_edge_delay #(.FALL(1'b0), .W(16)) u_rise (
		.core_clk(core_clk),
		.nrst(nrst),
		.x(red_in),
		.tick(dt_tick),
		.value(rise_delay_value),
		.y(red_raw)
	);

	pdcf_edge_delay #(.FALL(1'b1), .W(16)) u_fall (
		.core_clk(core_clk),
		.nrst(nrst),
		.x(fed_in),
		.tick(dt_tick),
		.value(fall_delay_value),
		.y(fed_raw)
	);

	// bypass, polarity and swap selection
	assign a_dt = sw[pdcf_pkg::SW_A_BYPASS] ? gen_a
		: (red_raw ^ sw[pdcf_pkg::SW_RISE_INV]);
	assign b_dt = sw[pdcf_pkg::SW_B_BYPASS] ? gen_b
		: (fed_raw ^ sw[pdcf_pkg::SW_FALL_INV]);
	assign chop_in[0] = sw[pdcf_pkg::SW_A_SWAP] ? b_dt : a_dt;
	assign chop_in[1] = sw[pdcf_pkg::SW_B_SWAP] ? a_dt : b_dt;

	// carrier fields
	assign chop_enable = chop_config[pdcf_pkg::CHOP_EN_BIT];
	assign chop_prescale = chop_config[pdcf_pkg::CHOP_PRE_LSB +: pdcf_pkg::PRE_W];
	assign chop_duty = chop_config[pdcf_pkg::CHOP_DUTY_LSB +: 3];
	assign first_pulse_width = chop_config[pdcf_pkg::CHOP_OSW_LSB +: 4];

	// free-running chop clock and eight-step carrier phase
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt <= '0;
			phase <= '0;
		end else if (chop_tick) begin
			pre_cnt <= '0;
			phase <= phase + 3'h1;
		end else begin
			pre_cnt <= pre_cnt + 4'h1;
		end
	end
	assign chop_tick = pre_cnt >= chop_prescale;
	assign carrier = phase < chop_duty;

	// first pulse length in operator clocks
	assign os_mult = (10'(chop_prescale) + 10'h1) * (10'(first_pulse_width) + 10'h1);
	assign os_load = 12'(os_mult) << pdcf_pkg::OS_SHIFT;

	// one-shot counters, restarted on every rise of each channel
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			chop_q <= '0;
			os_left[0] <= '0;
			os_left[1] <= '0;
		end else begin
			chop_q <= chop_in;
			for (int i = 0; i < 2; i++) begin
				if (!chop_in[i]) begin
					os_left[i] <= '0;
				end else if (!chop_q[i]) begin
					os_left[i] <= os_load - 12'h1;
				end else if (os_left[i] != '0) begin
					os_left[i] <= os_left[i] - 12'h1;
				end
			end
		end
	end

	// chopped signal; disabled carrier passes the signal as it is
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chop_out[i] = chop_in[i];
			if (chop_enable) begin
				chop_out[i] = chop_in[i] & (~chop_q[i] | os_left[i] != '0 | carrier);
			end
		end
	end

	// fault event selection
	assign fh_en = fh_cfg[pdcf_pkg::FH_EN_BIT];
	assign per_cycle_src = flt & fh_cfg[pdcf_pkg::FH_CBC_LSB +: 3];
	assign latched_src = flt & fh_cfg[pdcf_pkg::FH_OST_LSB +: 3];
	assign per_cycle_hit = fh_en & ((|per_cycle_src) | fh_cfg[pdcf_pkg::FH_SWCBC_BIT]);
	assign latched_hit = fh_en & ((|latched_src) | sw_latched_pulse);
	assign release_evt = fh_cfg[pdcf_pkg::FH_REL_BIT] ? timer_at_period : timer_at_zero;
	assign clr_tgl = fh_cfg[pdcf_pkg::FH_CLR_BIT] ^ clr_q;

	// trip flags; a new hit wins over release or clear in the same cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			per_cycle_on <= 1'b0;
			latched_on <= 1'b0;
			clr_q <= 1'b0;
		end else begin
			clr_q <= fh_cfg[pdcf_pkg::FH_CLR_BIT];
			if (per_cycle_hit) begin
				per_cycle_on <= 1'b1;
			end else if (release_evt || !fh_en) begin
				per_cycle_on <= 1'b0;
			end
			if (latched_hit) begin
				latched_on <= 1'b1;
			end else if (clr_tgl || !fh_en) begin
				latched_on <= 1'b0;
			end
		end
	end
	assign trip_now = per_cycle_hit | per_cycle_on | latched_hit | latched_on;

	// toggle reference: inverse of the level just before the trip began
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tog_lvl <= '0;
		end else if (!(per_cycle_on | latched_on)) begin
			tog_lvl <= ~chop_out;
		end
	end

	// forcing, latched trip over per-cycle; action group {latched, out b, down}
	always_comb begin
		pdcf_pkg::pdcf_act_e act;
		act = pdcf_pkg::PDCF_ACT_NONE;
		for (int k = 0; k < 2; k++) begin
			act = pdcf_pkg::pdcf_act_e'(fh_act[{(latched_hit | latched_on),
				1'(k), ~timer_up, 1'b0} +: 2]);
			next_out[k] = chop_out[k];
			if (trip_now) begin
				case (act)
					pdcf_pkg::PDCF_ACT_LOW: next_out[k] = 1'b0;
					pdcf_pkg::PDCF_ACT_HIGH: next_out[k] = 1'b1;
					pdcf_pkg::PDCF_ACT_TOGGLE: next_out[k] = (per_cycle_on | latched_on)
						? tog_lvl[k] : ~chop_out[k];
					default: next_out[k] = chop_out[k];
				endcase
			end
		end
	end

	// registered outputs and per-fault events on each rising level of a selected fault while enabled
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			operator_out_a <= 1'b0;
			operator_out_b <= 1'b0;
			per_cycle_trip_active <= 1'b0;
			latched_trip_active <= 1'b0;
			per_cycle_event <= '0;
			latched_event <= '0;
		end else begin
			operator_out_a <= next_out[0];
			operator_out_b <= next_out[1];
			per_cycle_trip_active <= per_cycle_on;
			latched_trip_active <= latched_on;
			per_cycle_event <= {3{fh_en}} & per_cycle_src & ~flt_q;
			latched_event <= {3{fh_en}} & latched_src & ~flt_q;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// bypass with no carrier and no trip copies inputs
	property p_bypass;
		sw[pdcf_pkg::SW_A_BYPASS] && sw[pdcf_pkg::SW_B_BYPASS] && !sw[6] && !sw[7]
			&& !chop_enable && !trip_now
			|=> operator_out_a == $past(gen_a) && operator_out_b == $past(gen_b);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not transparent");

	// latched trip holds without a clear toggle or disable
	property p_latched_hold;
		latched_on && !clr_tgl && fh_en |=> latched_on;
	endproperty
	a_latched_hold: assert property (p_latched_hold) else $error("latched trip dropped");

	// per-cycle trip waits for the release point
	property p_cycle_hold;
		per_cycle_on && !release_evt && fh_en |=> per_cycle_on;
	endproperty
	a_cycle_hold: assert property (p_cycle_hold) else $error("per-cycle released early");

	// status follows a hit two edges later
	property p_status;
		per_cycle_hit |=> ##1 per_cycle_trip_active;
	endproperty
	a_status: assert property (p_status) else $error("status missed trip");

	// low input keeps carrier output low
	property p_low_input;
		chop_enable && !chop_in[0] && !trip_now |=> !operator_out_a;
	endproperty
	a_low_input: assert property (p_low_input) else $error("carrier out high on low input");

	// first pulse counter loaded on a rise
	property p_first_pulse;
		chop_in[0] && !chop_q[0] |=> os_left[0] == $past(os_load) - 12'h1;
	endproperty
	a_first_pulse: assert property (p_first_pulse) else $error("first pulse length wrong");

	// carrier phase wraps after eight steps
	property p_phase_wrap;
		chop_tick && phase == 3'h7 |=> phase == 3'h0 && pre_cnt == 4'h0;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("carrier phase wrap wrong");

	// latched high action drives output a high next edge
	property p_latched_high;
		latched_hit && timer_up && fh_act[9:8] == 2'b10 |=> operator_out_a;
	endproperty
	a_latched_high: assert property (p_latched_high) else $error("latched high not applied");
endmodule
`default_nettype wire

// File: testbench/pdcf_fault_src.sv
// fault sensor model: drives the three fault pins with a minimum pulse width
`timescale 1ns/100ps
`default_nettype none
module pdcf_fault_src #(
	parameter int HOLD = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// requested fault levels and pin levels
	input wire logic [2:0] req,
	output logic [2:0] fault
);
	logic [2:0][7:0] cnt;
	// a one-cycle request still stands HOLD cycles so the pin sync sees it
	always @(posedge core_clk or negedge nrst) begin
		for (int k = 0; k < 3; k++) begin
			if (!nrst)
				cnt[k] <= 8'h00;
			else if (req[k])
				cnt[k] <= 8'(HOLD);
			else if (cnt[k] != 8'h00)
				cnt[k] <= cnt[k] - 8'h01;
		end
	end
	// active-high levels, actively driven low between faults
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			fault[k] = req[k] | (cnt[k] != 8'h00);
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_pdcf_top.sv
// self-checking bench for the dead-time, carrier and fault output stage
`timescale 1ns/100ps
`default_nettype none
module tb_pdcf_top;
	logic core_clk, nrst, wr, rd, gen_a, gen_b, timer_up, t_zero, t_per, tclk;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] fault_req, fault, pc_ev, lt_ev, seen_pc, seen_lt;
	logic op_a, op_b, pc_on, lt_on;
	logic [3:0] mon;
	int err_total, check_count, n0, n1, n2;
	// rows: cfg, gen_a, gen_b, out_a, out_b; selects, swaps, dual-edge kept 0
	localparam logic [13:0] ROWS [8] = '{14'h03a, 14'h08a, 14'h081, 14'h049,
		14'h00b, 14'h0c8, 14'h02b, 14'h015};
	assign mon = {lt_on, pc_on, op_b, op_a};

	pdcf_fault_src sensors (.core_clk(core_clk), .nrst(nrst), .req(fault_req), .fault(fault));
	pdcf_top dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .gen_a(gen_a), .gen_b(gen_b), .timer_up(timer_up),
		.timer_at_zero(t_zero), .timer_at_period(t_per), .timer_clock(tclk),
		.fault_in_0(fault[0]), .fault_in_1(fault[1]), .fault_in_2(fault[2]),
		.operator_out_a(op_a), .operator_out_b(op_b), .per_cycle_trip_active(pc_on),
		.latched_trip_active(lt_on), .per_cycle_event(pc_ev), .latched_event(lt_ev));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// sticky record of event pulses, cleared only while reset is low
	always @(posedge core_clk) begin
		seen_pc <= nrst ? (seen_pc | pc_ev) : 3'h0;
		seen_lt <= nrst ? (seen_lt | lt_ev) : 3'h0;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// bounded wait on one monitored output, returns cycles taken
	task automatic wt(input int w, input logic v, output int c);
		c = 0;
		while (mon[w] !== v && c < 200) begin
			@(posedge core_clk);
			#1;
			c++;
		end
		if (c == 200) begin
			err_total++;
			$display("[FAIL] wait on output %0d expected %b", w, v);
			end_of_test();
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
	endtask
	task automatic tick(input logic per);
		@(posedge core_clk);
		t_per <= per;
		t_zero <= ~per;
		@(posedge core_clk);
		t_per <= 1'b0;
		t_zero <= 1'b0;
	endtask
	task automatic pulse_fault(input int i);
		@(posedge core_clk);
		fault_req[i] <= 1'b1;
		@(posedge core_clk);
		fault_req[i] <= 1'b0;
	endtask
	task automatic set_gen(input logic a, input logic b);
		@(posedge core_clk);
		gen_a <= a;
		gen_b <= b;
		#1;
	endtask

	initial begin
		{nrst, wr, rd, gen_a, gen_b, t_zero, t_per, tclk} = '0;
		timer_up = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		fault_req = 3'h0;
		{err_total, check_count} = '0;
		repeat (10) @(posedge core_clk);
		#1;
		chk("out during reset", 32'h0, {30'h0, op_b, op_a});
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		// reset values, independent delay words, refused accesses
		rd_reg(pdcf_pkg::DT_CFG_ADDR, 32'h003);
		rd_reg(pdcf_pkg::CHOP_CFG_ADDR, 32'h0);
		rd_reg(pdcf_pkg::FH_CFG_ADDR, 32'h0);
		wr_reg(pdcf_pkg::RISE_DLY_ADDR, 32'hffff);
		wr_reg(pdcf_pkg::FALL_DLY_ADDR, 32'h1234);
		wr_reg(8'h1c, 32'hffffffff);
		wr_reg(pdcf_pkg::STATUS_ADDR, 32'h3);
		rd_reg(pdcf_pkg::RISE_DLY_ADDR, 32'hffff);
		rd_reg(pdcf_pkg::FALL_DLY_ADDR, 32'h1234);
		rd_reg(8'h1c, 32'h0);
		rd_reg(pdcf_pkg::STATUS_ADDR, 32'h0);
		wr_reg(pdcf_pkg::RISE_DLY_ADDR, 32'h0);
		wr_reg(pdcf_pkg::FALL_DLY_ADDR, 32'h0);
		// static dead-time modes with zero delays
		foreach (ROWS[r]) begin
			wr_reg(pdcf_pkg::DT_CFG_ADDR, {22'h0, ROWS[r][13:4]});
			set_gen(ROWS[r][3], ROWS[r][2]);
			repeat (6) @(posedge core_clk);
			#1;
			chk("dead-time outputs", {30'h0, ROWS[r][1:0]}, {30'h0, op_a, op_b});
		end
		// edge delays in counted core clock periods, rise and fall apart
		wr_reg(pdcf_pkg::DT_CFG_ADDR, 32'h000);
		set_gen(1'b0, 1'b0);
		repeat (5) @(posedge core_clk);
		set_gen(1'b1, 1'b0);
		wt(0, 1'b1, n0);
		set_gen(1'b0, 1'b0);
		repeat (8) @(posedge core_clk);
		wr_reg(pdcf_pkg::RISE_DLY_ADDR, 32'h5);
		wr_reg(pdcf_pkg::FALL_DLY_ADDR, 32'h3);
		set_gen(1'b1, 1'b0);
		wt(0, 1'b1, n1);
		chk("rise delay", 32'h5, 32'(n1 - n0));
		repeat (10) @(posedge core_clk);
		set_gen(1'b0, 1'b0);
		wt(0, 1'b0, n0);
		wt(1, 1'b0, n2);
		chk("fall delay", 32'h3, 32'(n2));
		// timer_clock as delay clock: a rising edge every four clocks, the first at
		// clock 3, so the fifth at clock 19; then five clocks of sync and edge detect
		// and one output flop
		wr_reg(pdcf_pkg::DT_CFG_ADDR, 32'h200);
		set_gen(1'b1, 1'b0);
		n1 = 0;
		while (op_a !== 1'b1 && n1 < 60) begin
			@(posedge core_clk);
			tclk <= n1[1];
			n1++;
			#1;
		end
		chk("timer clock delay", 32'd25, 32'(n1));
		set_gen(1'b0, 1'b0);
		// carrier: prescale 0, width 1, so a 16-cycle first pulse; duty 0 while it
		// is timed, since a free-running high carrier phase would stretch it
		wr_reg(pdcf_pkg::DT_CFG_ADDR, 32'h003);
		for (int p = 0; p < 2; p++) begin
			wr_reg(pdcf_pkg::CHOP_CFG_ADDR, 32'h101);
			set_gen(1'b1, 1'b0);
			wt(0, 1'b1, n0);
			wt(0, 1'b0, n1);
			chk("first pulse", 32'd16, 32'(n1));
			wr_reg(pdcf_pkg::CHOP_CFG_ADDR, 32'h181);
			n2 = 0;
			repeat (64) begin
				@(posedge core_clk);
				#1;
				n2 += int'(op_a);
			end
			chk("chopped highs", 32'd32, 32'(n2));
			set_gen(1'b0, 1'b0);
			repeat (3) @(posedge core_clk);
			n2 = 0;
			repeat (16) begin
				@(posedge core_clk);
				#1;
				n2 += int'(op_a);
			end
			chk("low phase highs", 32'd0, 32'(n2));
		end
		wr_reg(pdcf_pkg::CHOP_CFG_ADDR, 32'h0);
		// per-cycle trip on fault 0: A up high, B up low, release at zero
		set_gen(1'b0, 1'b1);
		wr_reg(pdcf_pkg::FH_ACT_ADDR, 32'h0012);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h003);
		pulse_fault(0);
		wt(0, 1'b1, n0);
		chk("cbc out_b", 32'h0, {31'h0, op_b});
		repeat (2) @(posedge core_clk);
		#1;
		chk("cbc status", 32'h1, {31'h0, pc_on});
		repeat (10) @(posedge core_clk);
		tick(1'b1);
		repeat (3) @(posedge core_clk);
		#1;
		chk("cbc held", 32'h1, {31'h0, op_a});
		tick(1'b0);
		wt(0, 1'b0, n0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("cbc released", 32'h1, {30'h0, pc_on, op_b});
		pulse_fault(2);
		repeat (12) @(posedge core_clk);
		#1;
		chk("unselected fault", 32'h0, {31'h0, pc_on});
		chk("cbc events", 32'h1, {29'h0, seen_pc});
		// latched trip on fault 1: A up low, B up toggle
		set_gen(1'b1, 1'b1);
		wr_reg(pdcf_pkg::FH_ACT_ADDR, 32'h3100);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h021);
		pulse_fault(1);
		wt(3, 1'b1, n0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("ost outputs", 32'h0, {30'h0, op_a, op_b});
		chk("ost events", 32'h2, {29'h0, seen_lt});
		repeat (10) @(posedge core_clk);
		tick(1'b0);
		tick(1'b1);
		repeat (5) @(posedge core_clk);
		#1;
		chk("ost persists", 32'h2, {30'h0, lt_on, op_a});
		rd_reg(pdcf_pkg::STATUS_ADDR, 32'h2);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h421);
		wt(3, 1'b0, n0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("ost cleared", 32'h3, {30'h0, op_a, op_b});
		// software force while counting down, then disable
		@(posedge core_clk);
		timer_up <= 1'b0;
		wr_reg(pdcf_pkg::FH_ACT_ADDR, 32'h0004);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h101);
		wt(2, 1'b1, n0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("sw cbc down", 32'h0, {31'h0, op_a});
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h100);
		wt(2, 1'b0, n0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("disabled", 32'h1, {31'h0, op_a});
		// enable first: a force in the enabling write still meets the old enable
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h001);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h201);
		wt(3, 1'b1, n0);
		wr_reg(pdcf_pkg::FH_CFG_ADDR, 32'h000);
		wt(3, 1'b0, n0);
		chk("sw ost cleared", 32'h0, {31'h0, lt_on});
		end_of_test();
	end
endmodule
`default_nettype wire
